// *** hw/mfb_consts.vh ***
`ifndef MFB_CONSTS_VH
`define MFB_CONSTS_VH
// Summary of operation
// - 68 inputs, true and complement, feed 164 terms
// - 160 logic terms, four shared control terms
// - five consecutive terms per macrocell cluster
// - cluster terms give OE, clock, preset, reset
// - two OR gates per macrocell, 64 total
// - bypass OR sums own cluster, feeds macrocell
// - expandable OR chains from N-7 to N+7
// - carry ripples macrocell 0 up to 31
// - first carry in: neighbour, zero or one
// - non-arithmetic macrocells pass carry unchanged
// - 32 macrocells fed by sharing, bypass or carry sum
// - XOR plus storage, combinational or registered
// - pool output plus unrelated output routing
// - direct I/O input to storage element
// - selectable clock, enable gates the update
// - global/term reset and preset, register or latch
// - 16384-bit memory, widths 1 to 32
// - write side always registered, one clock/enable
// - read address/data optionally registered, shared clock
// - port reset is global OR optionally inverted local
// - port clock: dedicated or global line, invertible
// - port enable: dedicated or global 1-2, invertible

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define MFB_A_CTRL      12'h000
`define MFB_A_MEMCFG    12'h001
`define MFB_A_POOL      12'h002
`define MFB_A_CARRY     12'h003
`define MFB_A_MC_BASE   12'h020
`define MFB_A_FUSE_BASE 12'h400

// ----------------------------------------
// sizes
// ----------------------------------------
`define MFB_NUM_IN  68
`define MFB_NUM_PT  164
`define MFB_NUM_MC  32
`define MFB_PT_CLK  160
`define MFB_PT_CE   161
`define MFB_PT_RST  162
`define MFB_PT_OE   163
`define MFB_CASC    7
`define MFB_FUSE_W  5

// ----------------------------------------
// reset values
// ----------------------------------------
`define MFB_CTRL_RST   3'h0
`define MFB_MEMCFG_RST 20'h00005
`define MFB_MC_RST     21'h000001
`define MFB_FUSE_RST   160'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define MFB_CT_MODE   0
`define MFB_CT_CIN    1
`define MFB_MC_BYP    0
`define MFB_MC_XOR    1
`define MFB_MC_REGD   2
`define MFB_MC_LATCH  3
`define MFB_MC_IOIN   4
`define MFB_MC_CLK    5
`define MFB_MC_CE     7
`define MFB_MC_LPRE   9
`define MFB_MC_LRST   10
`define MFB_MC_SRST   11
`define MFB_MC_ARITH  12
`define MFB_MC_LOE    13
`define MFB_MC_CASC   14
`define MFB_MC_SHR    15
`define MFB_MC_IOSRC  20
`define MFB_MM_WID    0
`define MFB_MM_WCK    3
`define MFB_MM_WCKI   6
`define MFB_MM_WCE    7
`define MFB_MM_WCEI   9
`define MFB_MM_RCK    10
`define MFB_MM_RCKI   13
`define MFB_MM_RCE    14
`define MFB_MM_RCEI   16
`define MFB_MM_RAREG  17
`define MFB_MM_RDREG  18
`define MFB_MM_MRSTI  19

`endif

// *** hw/mfb_macrocell.v ***
`timescale 1ns/1ps
`include "mfb_consts.vh"
module mfb_macrocell (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire [20:0] cfg,
  input  wire        d_in,
  input  wire        io_in,
  input  wire [3:0]  clk_src,
  input  wire        g_ce,
  input  wire        s_ce,
  input  wire        g_rst,
  input  wire        g_pre,
  input  wire        s_rst,
  input  wire        l_rst,
  input  wire        l_pre,
  output wire        pool_q,
  output wire        io_q
);
  reg  q_reg;
  reg  ck_prev_reg;
  reg  ce;
  wire comb = d_in ^ cfg[`MFB_MC_XOR];
  wire dsrc = cfg[`MFB_MC_IOIN] ? io_in : comb;
  wire ck   = clk_src[cfg[`MFB_MC_CLK +: 2]];
  wire rst  = g_rst | (cfg[`MFB_MC_SRST] & s_rst) | (cfg[`MFB_MC_LRST] & l_rst);
  wire pre  = g_pre | (cfg[`MFB_MC_LPRE] & l_pre);

  always @* begin
    case (cfg[`MFB_MC_CE +: 2])
      2'h1:    ce = g_ce;
      2'h2:    ce = s_ce;
      default: ce = 1'b1;
    endcase
  end

  // latch mode follows data while the gate is high, one core cycle late
  wire upd = ce & (cfg[`MFB_MC_LATCH] ? ck : (ck & ~ck_prev_reg));

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg       <= 1'b0;
      ck_prev_reg <= 1'b0;
    end else begin
      ck_prev_reg <= ck;
      // reset wins over preset
      if (rst)
        q_reg <= 1'b0;
      else if (pre)
        q_reg <= 1'b1;
      else if (upd)
        q_reg <= dsrc;
    end
  end

  assign pool_q = cfg[`MFB_MC_REGD] ? q_reg : comb;
  assign io_q   = cfg[`MFB_MC_IOSRC] ? comb : pool_q;
endmodule

// *** hw/mfb_top.v ***
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "mfb_consts.vh"
module mfb_top (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [67:0] global_routing_pool_in,
  output wire [31:0] global_routing_pool_out,
  input  wire [31:0] io_direct_in,
  output wire [15:0] output_steering_data,
  output wire [15:0] output_steering_oe,
  input  wire [3:0]  global_clock_lines,
  input  wire        global_clock_enable,
  input  wire        global_reset,
  input  wire        global_preset,
  input  wire        global_oe,
  input  wire        carry_in_adj,
  output wire        carry_out_adj,
  input  wire        wr_clk,
  input  wire        write_port_clock_enable,
  input  wire [13:0] wr_addr,
  input  wire [31:0] wr_data,
  input  wire        wr_cs,
  input  wire        wr_en,
  input  wire        rd_clk,
  input  wire        read_port_clock_enable,
  input  wire [13:0] rd_addr,
  input  wire        mem_rst,
  output wire [31:0] rd_data
);
  // ----------------------------------------
  // configuration state
  // ----------------------------------------
  reg  [2:0]   ctrl_reg;
  reg  [19:0]  memcfg_reg;
  reg  [20:0]  mc_cfg_reg [0:31];
  reg  [159:0] fuse_reg [0:163];
  reg          wait_reg;
  reg  [31:0]  readdata_reg;
  reg  [31:0]  rmux;
  integer      i;

  wire [163:0] pt;
  wire [31:0]  byp_or;
  wire [31:0]  exp_or;
  wire [32:0]  carry;
  wire [31:0]  pool_q;
  wire [31:0]  io_q;
  wire [135:0] lines = {~global_routing_pool_in, global_routing_pool_in};

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          be_merge[b*8 +: 8] = new_v[b*8 +: 8];
    end
  endfunction

  function [31:0] width_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0:    width_mask = 32'h00000001;
        3'h1:    width_mask = 32'h00000003;
        3'h2:    width_mask = 32'h0000000F;
        3'h3:    width_mask = 32'h000000FF;
        3'h4:    width_mask = 32'h0000FFFF;
        default: width_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        req    = avs_read | avs_write;
  wire        wr_go  = avs_write & ~wait_reg;
  wire [11:0] f_idx  = avs_address - `MFB_A_FUSE_BASE;
  wire [7:0]  f_pt   = f_idx[10:3];
  wire [2:0]  f_w    = f_idx[2:0];
  wire [7:0]  f_off  = {f_w, 5'h00};
  wire        f_hit  = (avs_address >= `MFB_A_FUSE_BASE) & ~f_idx[11] &
                       (f_pt < `MFB_NUM_PT) & (f_w < `MFB_FUSE_W);
  wire        mc_hit = (avs_address[11:5] == `MFB_A_MC_BASE >> 5);
  wire [4:0]  mc_sel = avs_address[4:0];

  always @* begin
    rmux = 32'h00000000;
    if (avs_address == `MFB_A_CTRL)
      rmux = {29'h0, ctrl_reg};
    else if (avs_address == `MFB_A_MEMCFG)
      rmux = {12'h000, memcfg_reg};
    else if (avs_address == `MFB_A_POOL)
      rmux = pool_q;
    else if (avs_address == `MFB_A_CARRY)
      rmux = {31'h0, carry[32]};
    else if (mc_hit)
      rmux = {11'h000, mc_cfg_reg[mc_sel]};
    else if (f_hit)
      rmux = fuse_reg[f_pt][f_off +: 32];
  end

  // one wait state: each access completes on the second edge
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg     <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else if (req & wait_reg) begin
      wait_reg <= 1'b0;
      if (avs_read)
        readdata_reg <= rmux;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = readdata_reg;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // merged words are cut to each register's width on purpose
  wire [31:0] ctrl_mrg   = be_merge({29'h0, ctrl_reg}, avs_writedata, avs_byteenable);
  wire [31:0] memcfg_mrg = be_merge({12'h000, memcfg_reg}, avs_writedata, avs_byteenable);
  wire [31:0] mc_mrg     = be_merge({11'h000, mc_cfg_reg[mc_sel]}, avs_writedata, avs_byteenable);
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg   <= `MFB_CTRL_RST;
      memcfg_reg <= `MFB_MEMCFG_RST;
      for (i = 0; i < `MFB_NUM_MC; i = i + 1)
        mc_cfg_reg[i] <= `MFB_MC_RST;
      // all fuses set: a term sees a line and its complement, so it reads 0
      for (i = 0; i < `MFB_NUM_PT; i = i + 1)
        fuse_reg[i] <= `MFB_FUSE_RST;
    end else if (wr_go) begin
      if (avs_address == `MFB_A_CTRL)
        ctrl_reg <= ctrl_mrg[2:0];
      else if (avs_address == `MFB_A_MEMCFG)
        memcfg_reg <= memcfg_mrg[19:0];
      else if (mc_hit)
        mc_cfg_reg[mc_sel] <= mc_mrg[20:0];
      else if (f_hit)
        fuse_reg[f_pt][f_off +: 32] <= be_merge(fuse_reg[f_pt][f_off +: 32],
                                                avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------
  // AND plane
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MFB_NUM_PT; g = g + 1) begin : g_pt
      // wired AND over every connected line
      assign pt[g] = &(lines | ~fuse_reg[g][135:0]);
    end
  endgenerate

  // ----------------------------------------
  // carry in select
  // ----------------------------------------
  wire [1:0] cin_sel = ctrl_reg[`MFB_CT_CIN +: 2];
  assign carry[0] = (cin_sel == 2'h2) ? carry_in_adj :
                    (cin_sel == 2'h1) ? 1'b1 : 1'b0;
  assign carry_out_adj = carry[32];

  // ----------------------------------------
  // dual OR stage and macrocells
  // ----------------------------------------
  generate
    for (g = 0; g < `MFB_NUM_MC; g = g + 1) begin : g_mc
      wire [4:0]  cl   = pt[g*5 +: 5];
      wire [20:0] cfg  = mc_cfg_reg[g];
      wire        arith = cfg[`MFB_MC_ARITH];
      wire        op_a = cl[0];
      wire        op_b = cl[1];
      wire        sum  = op_a ^ op_b ^ carry[g];
      wire        chain_in;
      wire        d_in;

      assign byp_or[g] = |cl;
      if (g >= `MFB_CASC) begin : g_casc
        assign chain_in = cfg[`MFB_MC_CASC] & exp_or[g - `MFB_CASC];
      end else begin : g_nocasc
        assign chain_in = 1'b0;
      end
      assign exp_or[g] = (|cl) | chain_in;

      // unused cells let the carry pass around them
      assign carry[g+1] = arith ? ((op_a & op_b) | (carry[g] & (op_a ^ op_b)))
                                : carry[g];

      // sharing array picks any expandable gate
      assign d_in = arith ? sum :
                    cfg[`MFB_MC_BYP] ? byp_or[g] : exp_or[cfg[`MFB_MC_SHR +: 5]];

      mfb_macrocell u_mc (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .cfg      (cfg),
        .d_in     (d_in),
        .io_in    (io_direct_in[g]),
        .clk_src  ({cl[2], pt[`MFB_PT_CLK], global_clock_lines[1:0]}),
        .g_ce     (global_clock_enable),
        .s_ce     (pt[`MFB_PT_CE]),
        .g_rst    (global_reset),
        .g_pre    (global_preset),
        .s_rst    (pt[`MFB_PT_RST]),
        .l_rst    (cl[4]),
        .l_pre    (cl[3]),
        .pool_q   (pool_q[g]),
        .io_q     (io_q[g])
      );
    end
  endgenerate

  assign global_routing_pool_out = pool_q;

  // ----------------------------------------
  // output routing: even macrocells only
  // ----------------------------------------
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_out
      wire [20:0] ocfg = mc_cfg_reg[2*g];
      assign output_steering_data[g] = io_q[2*g];
      assign output_steering_oe[g]   = global_oe &
        (ocfg[`MFB_MC_LOE] ? pt[10*g] : pt[`MFB_PT_OE]);
    end
  endgenerate

  // ----------------------------------------
  // memory mode port clocks and enables
  // ----------------------------------------
  reg  [31:0] mem [0:511];
  reg         wck_lvl;
  reg         rck_lvl;
  reg         wce_lvl;
  reg         rce_lvl;
  reg         wck_prev_reg;
  reg         rck_prev_reg;
  reg  [13:0] wa_reg;
  reg  [31:0] wd_reg;
  reg         wcs_reg;
  reg         we_reg;
  reg         wpend_reg;
  reg  [13:0] ra_reg;
  reg  [31:0] rdata_reg;

  wire       mem_mode = ctrl_reg[`MFB_CT_MODE];
  wire [2:0] wid      = memcfg_reg[`MFB_MM_WID +: 3];
  wire [2:0] wck_sel  = memcfg_reg[`MFB_MM_WCK +: 3];
  wire [2:0] rck_sel  = memcfg_reg[`MFB_MM_RCK +: 3];
  wire [1:0] wce_sel  = memcfg_reg[`MFB_MM_WCE +: 2];
  wire [1:0] rce_sel  = memcfg_reg[`MFB_MM_RCE +: 2];

  always @* begin
    case (wck_sel)
      3'h1:    wck_lvl = global_clock_lines[0];
      3'h2:    wck_lvl = global_clock_lines[1];
      3'h3:    wck_lvl = global_clock_lines[2];
      3'h4:    wck_lvl = global_clock_lines[3];
      default: wck_lvl = wr_clk;
    endcase
    wck_lvl = wck_lvl ^ memcfg_reg[`MFB_MM_WCKI];
    case (rck_sel)
      3'h1:    rck_lvl = global_clock_lines[0];
      3'h2:    rck_lvl = global_clock_lines[1];
      3'h3:    rck_lvl = global_clock_lines[2];
      3'h4:    rck_lvl = global_clock_lines[3];
      default: rck_lvl = rd_clk;
    endcase
    rck_lvl = rck_lvl ^ memcfg_reg[`MFB_MM_RCKI];
    case (wce_sel)
      2'h1:    wce_lvl = global_clock_lines[1];
      2'h2:    wce_lvl = global_clock_lines[2];
      default: wce_lvl = write_port_clock_enable;
    endcase
    wce_lvl = wce_lvl ^ memcfg_reg[`MFB_MM_WCEI];
    case (rce_sel)
      2'h1:    rce_lvl = global_clock_lines[1];
      2'h2:    rce_lvl = global_clock_lines[2];
      default: rce_lvl = read_port_clock_enable;
    endcase
    rce_lvl = rce_lvl ^ memcfg_reg[`MFB_MM_RCEI];
  end

  wire w_tick = mem_mode & wck_lvl & ~wck_prev_reg & wce_lvl;
  wire r_tick = mem_mode & rck_lvl & ~rck_prev_reg & rce_lvl;
  // port reset acts at once, without waiting for a port clock edge
  wire mrst   = global_reset | (mem_rst ^ memcfg_reg[`MFB_MM_MRSTI]);

  // ----------------------------------------
  // memory array addressing
  // ----------------------------------------
  // codes above 5 read as 32 bits, so the bit shift stops at 5
  wire [2:0]  wsh    = (wid > 3'h5) ? 3'h5 : wid;
  wire [13:0] w_bit  = wa_reg << wsh;
  wire [31:0] w_mask = width_mask(wid) << w_bit[4:0];
  wire [13:0] ra_eff = memcfg_reg[`MFB_MM_RAREG] ? ra_reg : rd_addr;
  wire [13:0] r_bit  = ra_eff << wsh;
  wire [31:0] r_word = (mem[r_bit[13:5]] >> r_bit[4:0]) & width_mask(wid);

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wck_prev_reg <= 1'b0;
      rck_prev_reg <= 1'b0;
      wa_reg       <= 14'h0000;
      wd_reg       <= 32'h00000000;
      wcs_reg      <= 1'b0;
      we_reg       <= 1'b0;
      wpend_reg    <= 1'b0;
      ra_reg       <= 14'h0000;
      rdata_reg    <= 32'h00000000;
    end else begin
      wck_prev_reg <= wck_lvl;
      rck_prev_reg <= rck_lvl;
      if (mrst) begin
        wa_reg    <= 14'h0000;
        wd_reg    <= 32'h00000000;
        wcs_reg   <= 1'b0;
        we_reg    <= 1'b0;
        wpend_reg <= 1'b0;
        ra_reg    <= 14'h0000;
        rdata_reg <= 32'h00000000;
      end else begin
        wpend_reg <= w_tick;
        if (w_tick) begin
          wa_reg  <= wr_addr;
          wd_reg  <= wr_data;
          wcs_reg <= wr_cs;
          we_reg  <= wr_en;
        end
        if (r_tick) begin
          ra_reg    <= rd_addr;
          rdata_reg <= r_word;
        end
      end
    end
  end

  // write lands one cycle after capture, from the captured fields
  always @(posedge core_clk) begin
    if (wpend_reg & wcs_reg & we_reg & ~mrst)
      mem[w_bit[13:5]] <= (mem[w_bit[13:5]] & ~w_mask) |
                          ((wd_reg << w_bit[4:0]) & w_mask);
  end

  assign rd_data = memcfg_reg[`MFB_MM_RDREG] ? rdata_reg : r_word;
endmodule

// *** testbench/mfb_props.sv ***
`timescale 1ns/1ps
module mfb_props (
  input wire        core_clk,
  input wire        rst_b,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [67:0] global_routing_pool_in,
  input wire [15:0] output_steering_oe,
  input wire        global_oe,
  input wire        carry_in_adj,
  input wire        carry_out_adj
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // causes that may move the carry output
  // ----------------------------------------
  reg        wr_d1, wr_d2, cin_d1, cin_d2;
  reg [67:0] pool_d1, pool_d2;
  always @(posedge core_clk) begin
    wr_d1   <= avs_write;
    wr_d2   <= wr_d1;
    cin_d1  <= carry_in_adj;
    cin_d2  <= cin_d1;
    pool_d1 <= global_routing_pool_in;
    pool_d2 <= pool_d1;
  end
  wire cause = wr_d1 || wr_d2 || carry_in_adj != cin_d1 || cin_d1 != cin_d2 ||
               global_routing_pool_in != pool_d1 || pool_d1 != pool_d2;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_wait_req; !avs_waitrequest |-> (avs_read || avs_write); endproperty
  property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  property p_rd_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
  property p_rst_val; $rose(rst_b) |-> avs_waitrequest && avs_readdata == 32'h0; endproperty
  property p_oe_gate; !global_oe [*3] |-> output_steering_oe == 16'h0000; endproperty
  property p_carry; $changed(carry_out_adj) |-> cause; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered next cycle");
  a_wait_req: assert property (p_wait_req) else $error("waitrequest low without request");
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  a_rst_val: assert property (p_rst_val) else $error("bus outputs wrong after reset");
  a_oe_gate: assert property (p_oe_gate) else $error("output enable without global enable");
  a_carry: assert property (p_carry) else $error("carry out changed without cause");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_oe: cover property (output_steering_oe != 16'h0000);
endmodule

bind mfb_top mfb_props u_props (
  .core_clk               (core_clk),
  .rst_b                  (rst_b),
  .avs_read               (avs_read),
  .avs_write              (avs_write),
  .avs_readdata           (avs_readdata),
  .avs_waitrequest        (avs_waitrequest),
  .global_routing_pool_in (global_routing_pool_in),
  .output_steering_oe     (output_steering_oe),
  .global_oe              (global_oe),
  .carry_in_adj           (carry_in_adj),
  .carry_out_adj          (carry_out_adj)
);

// *** testbench/mfb_pool_model.sv ***
`timescale 1ns/1ps
module mfb_pool_model (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        drive_bit,
  output reg  [67:0] pool_in,
  output reg  [31:0] io_in
);
  // unused lines carry a fixed busy pattern so stray fuses would show
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pool_in <= {34{2'b10}};
      io_in   <= 32'hAAAA5554;
    end else begin
      pool_in[0] <= drive_bit;
    end
  end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  reg         core_clk = 1'b0, rst_b = 1'b0;
  reg  [11:0] avs_address = 12'h000;
  reg         avs_read = 1'b0, avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0, wr_data = 32'h0, rv;
  wire [31:0] avs_readdata, pool_out, io_in, rd_data;
  wire        avs_waitrequest, carry_out;
  wire [67:0] pool_in;
  wire [15:0] steer_data, steer_oe;
  reg  [3:0]  glb_clk = 4'h0;
  reg         glb_oe = 1'b0, carry_in = 1'b0, drive_bit = 1'b0, lo = 1'b0;
  reg         glb_ce = 1'b0, glb_rst = 1'b0, glb_pre = 1'b0;
  reg         wr_clk = 1'b0, wr_ce = 1'b0, wr_cs = 1'b0, wr_en = 1'b0;
  integer     n_mismatch = 0, checks = 0, cyc = 0, i;
  // {carry select, carry in, expected carry out}
  reg  [3:0]  crow [0:5] = '{4'h0, 4'h2, 4'h5, 4'h7, 4'h8, 4'hB};

  always #2 core_clk = ~core_clk;

  mfb_pool_model pm (.core_clk(core_clk), .rst_b(rst_b), .drive_bit(drive_bit), .pool_in(pool_in), .io_in(io_in));

  mfb_top dut (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_routing_pool_in(pool_in), .global_routing_pool_out(pool_out), .io_direct_in(io_in),
    .output_steering_data(steer_data), .output_steering_oe(steer_oe), .global_clock_lines(glb_clk),
    .global_clock_enable(glb_ce), .global_reset(glb_rst), .global_preset(glb_pre), .global_oe(glb_oe),
    .carry_in_adj(carry_in), .carry_out_adj(carry_out), .wr_clk(wr_clk),
    .write_port_clock_enable(wr_ce), .wr_addr(14'h0000), .wr_data(wr_data), .wr_cs(wr_cs),
    .wr_en(wr_en), .rd_clk(lo), .read_port_clock_enable(lo), .rd_addr(14'h0000), .mem_rst(lo),
    .rd_data(rd_data)
  );

  task final_report;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // request held until waitrequest is seen low, one idle edge after release
  task av(input wr, input [11:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
        t = t + 1;
        @(posedge core_clk);
      end
      chk("wait_states", t, 32'h1);
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // data changes right after the port clock to prove it was captured
  task mem_wr(input [31:0] d, input cs);
    begin
      wr_data <= d;
      wr_cs <= cs;
      wr_en <= 1'b1;
      wr_ce <= 1'b1;
      @(posedge core_clk);
      wr_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      wr_clk <= 1'b0;
      wr_cs <= 1'b0;
      wr_data <= ~d;
      repeat (4) @(posedge core_clk);
    end
  endtask

  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    av(0, 12'h001, 32'h0); chk("memcfg", rv, 32'h00005);
    av(0, 12'h020, 32'h0); chk("mc0_cfg", rv, 32'h1);
    av(1, 12'h010, 32'hFFFFFFFF);
    av(0, 12'h010, 32'h0); chk("unmapped", rv, 32'h0);
    chk("pool_rst", pool_out, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      av(1, 12'h000, {29'h0, crow[i][3:2], 1'b0});
      carry_in <= crow[i][1];
      repeat (2) @(posedge core_clk);
      chk("carry_out", {31'h0, carry_out}, {31'h0, crow[i][0]});
      av(0, 12'h003, 32'h0); chk("carry_reg", rv, {31'h0, crow[i][0]});
    end
    av(1, 12'h020, 32'h1000);
    chk("arith_kill", {31'h0, carry_out}, 32'h0);
    chk("arith_sum", {31'h0, pool_out[0]}, 32'h1);
    av(1, 12'h020, 32'h1);
    for (i = 0; i < 5; i = i + 1) av(1, 12'h400 + i[11:0], (i == 0) ? 32'h1 : 32'h0);
    drive_bit <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("bypass_hi", {31'h0, pool_out[0]}, 32'h1);
    chk("pool_rest", {1'b0, pool_out[31:1]}, 32'h0);
    av(1, 12'h027, 32'h3C000);
    repeat (2) @(posedge core_clk);
    chk("cascade", {31'h0, pool_out[7]}, 32'h1);
    drive_bit <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("follow_lo", {30'h0, pool_out[7], pool_out[0]}, 32'h0);
    av(1, 12'h400, 32'h0);
    av(1, 12'h402, 32'h10);
    chk("complement", {31'h0, pool_out[0]}, 32'h1);
    av(1, 12'h020, 32'h3);
    chk("xor_inv", {31'h0, pool_out[0]}, 32'h0);
    av(1, 12'h020, 32'h2001);
    glb_oe <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("oe_local", {31'h0, steer_oe[0]}, 32'h1);
    chk("steer", {31'h0, steer_data[0]}, 32'h1);
    glb_oe <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("oe_off", {16'h0, steer_oe}, 32'h0);
    av(1, 12'h020, 32'h5);
    repeat (4) @(posedge core_clk);
    chk("reg_hold", {31'h0, pool_out[0]}, 32'h0);
    glb_clk[0] <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("reg_cap", {31'h0, pool_out[0]}, 32'h1);
    drive_bit <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("reg_keep", {31'h0, pool_out[0]}, 32'h1);
    glb_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("g_rst", {31'h0, pool_out[0]}, 32'h0);
    glb_pre <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("rst_over_pre", {31'h0, pool_out[0]}, 32'h0);
    glb_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("g_pre", {31'h0, pool_out[0]}, 32'h1);
    glb_pre <= 1'b0;
    glb_clk[0] <= 1'b0;
    av(1, 12'h020, 32'h95);
    glb_clk[0] <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("ce_block", {31'h0, pool_out[0]}, 32'h1);
    glb_clk[0] <= 1'b0;
    glb_ce <= 1'b1;
    drive_bit <= 1'b0;
    repeat (2) @(posedge core_clk);
    glb_clk[0] <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("io_direct", {31'h0, pool_out[0]}, 32'h0);
    glb_clk[0] <= 1'b0;
    av(1, 12'h000, 32'h1);
    mem_wr(32'hA5C30F1E, 1'b1);
    chk("mem_wr", rd_data, 32'hA5C30F1E);
    mem_wr(32'h12345678, 1'b0);
    chk("mem_nocs", rd_data, 32'hA5C30F1E);
    mem_wr(32'h12345678, 1'b1);
    chk("mem_async", rd_data, 32'h12345678);
    av(1, 12'h001, 32'h3);
    chk("mem_width", rd_data, 32'h00000078);
    final_report;
  end
endmodule
